// ---- rtl/dacmx_defs.svh ----
// Purpose: constants for the output attenuation and monitor mix block
// Assumes: 16-bit registers on a plain strobe port, 16-bit samples
// Notes:   definitions only
`ifndef DACMX_DEFS_SVH
`define DACMX_DEFS_SVH

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define DACMX_ADDR_W        8
`define DACMX_ADDR_DAC2_ATT 8'h0C
`define DACMX_ADDR_MIX1     8'h0D
`define DACMX_ADDR_MIX2     8'h0E
`define DACMX_ADDR_STATUS   8'h10
`define DACMX_RST_DAC2_ATT  16'h0000
`define DACMX_RST_MIX       16'h8080
`define DACMX_REG_MASK      16'hBFBF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DACMX_L_MUTE        15
`define DACMX_L_ATT_HI      13
`define DACMX_L_ATT_LO      8
`define DACMX_R_MUTE        7
`define DACMX_R_ATT_HI      5
`define DACMX_R_ATT_LO      0
`define DACMX_STAT_HOLD     15

// ----------------------------------------------------------------
// datapath
// ----------------------------------------------------------------
`define DACMX_SAMP_W        16
`define DACMX_FIFO_DEPTH    16
`define DACMX_ATT_FULL      6'h3F
`define DACMX_ATT_ZERO      6'h00
`define DACMX_FRAC_1        16'h6BB3
`define DACMX_FRAC_2        16'h5A9E
`define DACMX_FRAC_3        16'h4C3F
`define DACMX_SAMP_MAX      16'h7FFF
`define DACMX_SAMP_MIN      16'h8000
`define DACMX_SYNC_RST      3'h0

`endif

// ---- rtl/dacmx_pkg.sv ----
// Purpose: types of the output attenuation and monitor mix block
// Assumes: nothing
// Notes:   state of the top module as one packed struct
package dacmx_pkg;

	typedef struct packed
	{
		logic [2:0]  rstSync;
		logic [2:0]  pwrSync;
		logic        rstPinOk;
		logic        pwrPinOk;
		logic [15:0] dac2Att;
		logic [15:0] mix1;
		logic [15:0] mix2;
		logic [15:0] rdData;
	} dacmx_top_st_t;

endpackage

// ---- rtl/dacmx_atten.sv ----
// Purpose: one channel of 1.5 dB-step digital attenuation with mute
// Assumes: combinational, signed 16-bit sample
// Notes:   four codes make a 6 dB shift, the remainder a fractional gain
`include "dacmx_defs.svh"

module dacmx_atten (
	input  wire logic signed [15:0] sample,
	input  wire logic        [5:0]  code,
	input  wire logic               mute,
	input  wire logic               fullMuteCode,
	output logic signed      [15:0] result
);

	logic        [15:0] frac;
	logic signed [32:0] prod;
	logic signed [15:0] scaled;
	logic        [3:0]  shiftCnt;
	logic        [1:0]  stepIdx;

	// ----------------------------------------------------------------
	// gain
	// ----------------------------------------------------------------
	always_comb
	begin
		shiftCnt = code[5:2];
		stepIdx  = code[1:0];
		case (stepIdx)
			2'h1:    frac = `DACMX_FRAC_1;
			2'h2:    frac = `DACMX_FRAC_2;
			2'h3:    frac = `DACMX_FRAC_3;
			default: frac = `DACMX_SAMP_MAX;
		endcase
		prod   = sample * $signed({1'b0, frac});
		// code zero is an exact bypass
		scaled = (stepIdx == 2'h0) ? sample : prod[30:15];
		if (mute || (fullMuteCode && (code == `DACMX_ATT_FULL)))
			result = '0;
		else
			result = scaled >>> shiftCnt;
	end

endmodule // dacmx_atten

// ---- rtl/dacmx_fifo.sv ----
// Purpose: sample FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   ready and the output word come straight from flip-flops
module dacmx_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData,
	output logic [$clog2(DEPTH):0] level
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wrPtr;
		logic [AW-1:0]               rdPtr;
		logic [AW:0]                 count;
		logic                        ready;
		logic                        outValid;
		logic [WIDTH-1:0]            outData;
	} dacmx_fifo_st_t;

	dacmx_fifo_st_t st_q;
	dacmx_fifo_st_t st_d;
	logic           push;
	logic           pop;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		push = inValid && st_q.ready && ce;
		pop  = (st_q.count != '0) && (!st_q.outValid || outReady) && ce;
		if (push)
		begin
			st_d.mem[st_q.wrPtr] = inData;
			st_d.wrPtr = st_q.wrPtr + AW'(1);
		end
		if (st_q.outValid && outReady && ce)
			st_d.outValid = 1'b0;
		if (pop)
		begin
			st_d.outData  = st_q.mem[st_q.rdPtr];
			st_d.outValid = 1'b1;
			st_d.rdPtr    = st_q.rdPtr + AW'(1);
		end
		st_d.count = st_q.count + (AW+1)'(push) - (AW+1)'(pop);
		// ready follows the next count, so full stalls the writer in the same cycle
		st_d.ready = (st_d.count < (AW+1)'(DEPTH));
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_q <= '0;
		else if (ce)
			st_q <= st_d;
	end

	assign inReady  = st_q.ready;
	assign outValid = st_q.outValid;
	assign outData  = st_q.outData;
	assign level    = st_q.count;

endmodule // dacmx_fifo

// ---- rtl/dacmx_top.sv ----
// Purpose: second-output attenuation and ADC monitor mix into both outputs
// Assumes: one sample set per conversion period on inValid/inReady
// Notes:   mixed samples pass a 16-word FIFO to the interpolators
//
// Overview of operation
// - Left second-output mute bit silences that channel when set.
// - Left second-output six-bit attenuation, 1.5 dB per step, up to 94.5 dB.
// - Right second-output mute bit silences that channel when set.
// - Right second-output attenuation uses the same 1.5 dB coding.
// - Second-output attenuation register resets to all zeros.
// - Registers held at default, writes ignored, while reset, powerdown or powerdown bit.
// - Left ADC mix into first output removed when its mute bit is set.
// - Mix attenuation 1.5 dB per step; all-ones code removes the mix.
// - Right ADC mix into first output: own mute and attenuation field.
// - First-output mix register resets to 0x8080, both paths muted.
// - Left ADC mix into second output removed when its mute bit is set.
// - Right ADC mix into second output: lower-byte mute and attenuation.
// - Second-output mix register resets to 0x8080, both paths muted.
//
// The implementer's own choice: the strobed register port.
`include "dacmx_defs.svh"

module dacmx_top (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     ce,
	input  wire logic                     resetPinN,
	input  wire logic                     powerdownPinN,
	input  wire logic                     globalConversionPowerdown,
	input  wire logic [`DACMX_ADDR_W-1:0] regAddr,
	input  wire logic [15:0]              regWrData,
	input  wire logic                     regWr,
	input  wire logic                     regRd,
	output logic [15:0]                   regRdData,
	input  wire logic                     inValid,
	output logic                          inReady,
	input  wire logic signed [15:0]       adcLeft,
	input  wire logic signed [15:0]       adcRight,
	input  wire logic signed [15:0]       out1LeftIn,
	input  wire logic signed [15:0]       out1RightIn,
	input  wire logic signed [15:0]       out2LeftIn,
	input  wire logic signed [15:0]       out2RightIn,
	output logic                          outValid,
	input  wire logic                     outReady,
	output logic signed [15:0]            out1Left,
	output logic signed [15:0]            out1Right,
	output logic signed [15:0]            out2Left,
	output logic signed [15:0]            out2Right
);

	localparam int NCH = 6;
	localparam int LVW = $clog2(`DACMX_FIFO_DEPTH) + 1;

	localparam dacmx_pkg::dacmx_top_st_t RST_STATE = '{
		rstSync:  `DACMX_SYNC_RST,
		pwrSync:  `DACMX_SYNC_RST,
		rstPinOk: 1'b0,
		pwrPinOk: 1'b0,
		dac2Att:  `DACMX_RST_DAC2_ATT,
		mix1:     `DACMX_RST_MIX,
		mix2:     `DACMX_RST_MIX,
		rdData:   16'h0000
	};

	dacmx_pkg::dacmx_top_st_t st_q;
	dacmx_pkg::dacmx_top_st_t st_d;

	logic                   holdDefault;
	logic                   acceptIn;
	logic [LVW-1:0]         fifoLevel;
	logic signed [15:0]     attIn   [NCH];
	logic signed [15:0]     attOut  [NCH];
	logic [5:0]             attCode [NCH];
	logic                   attMute [NCH];
	logic                   attFull [NCH];
	logic signed [15:0]     out1LeftW;
	logic signed [15:0]     out1RightW;
	logic signed [15:0]     sum2Left;
	logic signed [15:0]     sum2Right;
	logic signed [15:0]     out2LeftW;
	logic signed [15:0]     out2RightW;

	function automatic logic [15:0] satAdd(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {a[15], a} + {b[15], b};
		if (s[16] != s[15])
			satAdd = s[16] ? `DACMX_SAMP_MIN : `DACMX_SAMP_MAX;
		else
			satAdd = s[15:0];
	endfunction

	// ----------------------------------------------------------------
	// pin filtering, registers and read port
	// ----------------------------------------------------------------
	assign holdDefault = !st_q.rstPinOk || !st_q.pwrPinOk || globalConversionPowerdown;

	always_comb
	begin
		st_d = st_q;
		st_d.rstSync = {st_q.rstSync[1:0], resetPinN};
		st_d.pwrSync = {st_q.pwrSync[1:0], powerdownPinN};
		// a pin change counts once stages two and three agree
		if (st_q.rstSync[1] == st_q.rstSync[2])
			st_d.rstPinOk = st_q.rstSync[2];
		if (st_q.pwrSync[1] == st_q.pwrSync[2])
			st_d.pwrPinOk = st_q.pwrSync[2];
		// reserved bits are not stored and read zero
		if (regWr)
		begin
			case (regAddr)
				`DACMX_ADDR_DAC2_ATT: st_d.dac2Att = regWrData & `DACMX_REG_MASK;
				`DACMX_ADDR_MIX1:     st_d.mix1 = regWrData & `DACMX_REG_MASK;
				`DACMX_ADDR_MIX2:     st_d.mix2 = regWrData & `DACMX_REG_MASK;
				default:              ;
			endcase
		end
		if (holdDefault)
		begin
			st_d.dac2Att = `DACMX_RST_DAC2_ATT;
			st_d.mix1    = `DACMX_RST_MIX;
			st_d.mix2    = `DACMX_RST_MIX;
		end
		st_d.rdData = '0;
		if (regRd)
		begin
			case (regAddr)
				`DACMX_ADDR_DAC2_ATT: st_d.rdData = st_q.dac2Att;
				`DACMX_ADDR_MIX1:     st_d.rdData = st_q.mix1;
				`DACMX_ADDR_MIX2:     st_d.rdData = st_q.mix2;
				`DACMX_ADDR_STATUS:
				begin
					st_d.rdData = 16'(fifoLevel);
					st_d.rdData[`DACMX_STAT_HOLD] = holdDefault;
				end
				default:              st_d.rdData = '0;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_q <= RST_STATE;
		else if (ce)
			st_q <= st_d;
	end

	assign regRdData = st_q.rdData;

	// ----------------------------------------------------------------
	// attenuation channels: four mix paths, then the second output
	// ----------------------------------------------------------------
	assign attIn[0]   = adcLeft;
	assign attCode[0] = st_q.mix1[`DACMX_L_ATT_HI:`DACMX_L_ATT_LO];
	assign attMute[0] = st_q.mix1[`DACMX_L_MUTE];
	assign attIn[1]   = adcRight;
	assign attCode[1] = st_q.mix1[`DACMX_R_ATT_HI:`DACMX_R_ATT_LO];
	assign attMute[1] = st_q.mix1[`DACMX_R_MUTE];
	assign attIn[2]   = adcLeft;
	assign attCode[2] = st_q.mix2[`DACMX_L_ATT_HI:`DACMX_L_ATT_LO];
	assign attMute[2] = st_q.mix2[`DACMX_L_MUTE];
	assign attIn[3]   = adcRight;
	assign attCode[3] = st_q.mix2[`DACMX_R_ATT_HI:`DACMX_R_ATT_LO];
	assign attMute[3] = st_q.mix2[`DACMX_R_MUTE];
	assign attIn[4]   = sum2Left;
	assign attCode[4] = st_q.dac2Att[`DACMX_L_ATT_HI:`DACMX_L_ATT_LO];
	assign attMute[4] = st_q.dac2Att[`DACMX_L_MUTE];
	assign attIn[5]   = sum2Right;
	assign attCode[5] = st_q.dac2Att[`DACMX_R_ATT_HI:`DACMX_R_ATT_LO];
	assign attMute[5] = st_q.dac2Att[`DACMX_R_MUTE];

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : gAtt
			// only mix paths treat the all-ones code as full mute
			assign attFull[g] = (g < 4);
			dacmx_atten uAtten (
				.sample       (attIn[g]),
				.code         (attCode[g]),
				.mute         (attMute[g]),
				.fullMuteCode (attFull[g]),
				.result       (attOut[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// mixing with saturation
	// ----------------------------------------------------------------
	assign out1LeftW  = satAdd(out1LeftIn, attOut[0]);
	assign out1RightW = satAdd(out1RightIn, attOut[1]);
	assign sum2Left   = satAdd(out2LeftIn, attOut[2]);
	assign sum2Right  = satAdd(out2RightIn, attOut[3]);
	assign out2LeftW  = attOut[4];
	assign out2RightW = attOut[5];

	// ----------------------------------------------------------------
	// output buffer
	// ----------------------------------------------------------------
	dacmx_fifo #(
		.WIDTH (4 * `DACMX_SAMP_W),
		.DEPTH (`DACMX_FIFO_DEPTH)
	) uFifo (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.inValid  (inValid),
		.inReady  (inReady),
		.inData   ({out1LeftW, out1RightW, out2LeftW, out2RightW}),
		.outValid (outValid),
		.outReady (outReady),
		.outData  ({out1Left, out1Right, out2Left, out2Right}),
		.level    (fifoLevel)
	);

	assign acceptIn = inValid && inReady && ce;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence holdCycle;
		holdDefault && ce;
	endsequence

	sequence readMix1;
		ce && regRd && (regAddr == `DACMX_ADDR_MIX1);
	endsequence

	sequence readMix2;
		ce && regRd && (regAddr == `DACMX_ADDR_MIX2);
	endsequence

	hold_dac2_a: assert property (holdCycle |=> (st_q.dac2Att == `DACMX_RST_DAC2_ATT))
		else $error("attenuation register not at default while held");

	wr_blocked_a: assert property ((holdCycle ##0 regWr) |=>
		(st_q.mix1 == `DACMX_RST_MIX) && (st_q.mix2 == `DACMX_RST_MIX))
		else $error("write took effect while held");

	hold_mix1_a: assert property (holdCycle ##1 readMix1 |=> (regRdData == `DACMX_RST_MIX))
		else $error("first mix register does not read its default after hold");

	hold_mix2_a: assert property (holdCycle ##1 readMix2 |=> (regRdData == `DACMX_RST_MIX))
		else $error("second mix register does not read its default after hold");

	mute_out2l_a: assert property ((acceptIn && st_q.dac2Att[`DACMX_L_MUTE]) |->
		(out2LeftW == '0))
		else $error("left second output not silent while muted");

	mute_out2r_a: assert property ((acceptIn && st_q.dac2Att[`DACMX_R_MUTE]) |->
		(out2RightW == '0))
		else $error("right second output not silent while muted");

	zero_att_l_a: assert property (
		(acceptIn && (st_q.dac2Att[`DACMX_L_MUTE:`DACMX_L_ATT_LO] == '0)) |->
		(out2LeftW == sum2Left))
		else $error("left second output altered at zero attenuation");

	zero_att_r_a: assert property (
		(acceptIn && (st_q.dac2Att[`DACMX_R_MUTE:`DACMX_R_ATT_LO] == '0)) |->
		(out2RightW == sum2Right))
		else $error("right second output altered at zero attenuation");

	mix1l_mute_a: assert property ((acceptIn && st_q.mix1[`DACMX_L_MUTE]) |->
		(out1LeftW == out1LeftIn))
		else $error("left mix into first output present while muted");

	mix1r_mute_a: assert property ((acceptIn && st_q.mix1[`DACMX_R_MUTE]) |->
		(out1RightW == out1RightIn))
		else $error("right mix into first output present while muted");

	full_code_a: assert property ((acceptIn && (attCode[0] == `DACMX_ATT_FULL)) |->
		(out1LeftW == out1LeftIn))
		else $error("all-ones mix code did not remove the mix");

	mix2l_mute_a: assert property ((acceptIn && st_q.mix2[`DACMX_L_MUTE]) |->
		(sum2Left == out2LeftIn))
		else $error("left mix into second output present while muted");

	mix2r_mute_a: assert property ((acceptIn && st_q.mix2[`DACMX_R_MUTE]) |->
		(sum2Right == out2RightIn))
		else $error("right mix into second output present while muted");

	sat_pos_a: assert property ((acceptIn && !out1LeftIn[15] && !attOut[0][15]) |->
		!out1LeftW[15])
		else $error("positive mix wrapped negative");

	sat_neg_a: assert property ((acceptIn && out1RightIn[15] && attOut[1][15]) |->
		out1RightW[15])
		else $error("negative mix wrapped positive");

	mute_zero_a: assert property ((acceptIn && attMute[2]) |-> (attOut[2] == '0))
		else $error("muted mix path not zero");

endmodule // dacmx_top

// ---- dv/dacmx_sink_model.sv ----
// Purpose: consumer of the processed sample stream
// Assumes: stall is driven by the bench
// Notes:   keeps every taken word in arrival order
module dacmx_sink_model (
	input  wire logic        clk,
	input  wire logic        stall,
	input  wire logic        outValid,
	output logic             outReady,
	input  wire logic [63:0] word
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [63:0] got [$];

	assign outReady = !stall;

	always @(posedge clk)
	begin
		if (outValid === 1'b1 && outReady)
			got.push_back(word);
	end
endmodule // dacmx_sink_model

// ---- dv/tb_dacmx_top.sv ----
// Purpose: self-checking bench of the attenuation and monitor mix block
// Assumes: design assertions live in the design files
// Notes:   registers, hold sources, sample math, FIFO fill and drain
`include "dacmx_defs.svh"

module tb_dacmx_top;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clk, rst, ce, resetPinN, powerdownPinN, pdBit, regWr, regRd;
	logic        inValid, inReady, outValid, outReady, stall;
	logic [7:0]  regAddr;
	logic [15:0] regWrData, regRdData, o1L, o1R, o2L, o2R;
	logic [15:0] smp [6];
	int          fails, totalChecks, cycles, n;

	// dac2, mix1, mix2, adcL, adcR, in1L, in1R, in2L, in2R, expected out1L..out2R
	localparam logic [15:0] CASES [4][13] = '{
		'{16'h0000, 16'h8080, 16'h8080, 16'h1000, 16'h2000, 16'h0100, 16'h0200,
			16'h0300, 16'h0400, 16'h0100, 16'h0200, 16'h0300, 16'h0400},
		'{16'h0480, 16'h0004, 16'h3F80, 16'h1000, 16'h2000, 16'h7000, 16'h0100,
			16'h0300, 16'h0400, 16'h7FFF, 16'h1100, 16'h0180, 16'h0000},
		'{16'h8000, 16'h8000, 16'h0000, 16'h1000, 16'hC000, 16'h0100, 16'h9000,
			16'h0300, 16'h0400, 16'h0100, 16'h8000, 16'h0000, 16'hC400},
		'{16'h0106, 16'h3F02, 16'h8080, 16'h8000, 16'h4000, 16'h0100, 16'h0200,
			16'h4000, 16'h4000, 16'h0100, 16'h2F4F, 16'h35D9, 16'h16A7}};

	dacmx_top i_dacmx_top (
		.clk(clk), .rst(rst), .ce(ce), .resetPinN(resetPinN),
		.powerdownPinN(powerdownPinN), .globalConversionPowerdown(pdBit),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .inValid(inValid), .inReady(inReady),
		.adcLeft(smp[0]), .adcRight(smp[1]), .out1LeftIn(smp[2]), .out1RightIn(smp[3]),
		.out2LeftIn(smp[4]), .out2RightIn(smp[5]), .outValid(outValid),
		.outReady(outReady), .out1Left(o1L), .out1Right(o1R), .out2Left(o2L),
		.out2Right(o2R)
	);

	dacmx_sink_model i_dacmx_sink_model (
		.clk(clk), .stall(stall), .outValid(outValid), .outReady(outReady),
		.word({o1L, o1R, o2L, o2R})
	);

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		totalChecks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
		check(regRdData, e);
	endtask

	task automatic setRegs(input logic [15:0] d2, input logic [15:0] m1, input logic [15:0] m2);
		wr(`DACMX_ADDR_DAC2_ATT, d2);
		wr(`DACMX_ADDR_MIX1, m1);
		wr(`DACMX_ADDR_MIX2, m2);
	endtask

	task automatic regsChk(input logic [15:0] d2, input logic [15:0] m1, input logic [15:0] m2);
		rdChk(`DACMX_ADDR_DAC2_ATT, d2);
		rdChk(`DACMX_ADDR_MIX1, m1);
		rdChk(`DACMX_ADDR_MIX2, m2);
	endtask

	task automatic waitWords(input int cnt);
		n = 0;
		while (i_dacmx_sink_model.got.size() < cnt && n < 80)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	// one sample set per conversion period, all from one clock generator
	task automatic runCase(input int k);
		logic [63:0] w;
		setRegs(CASES[k][0], CASES[k][1], CASES[k][2]);
		inValid <= 1'b1;
		for (int i = 0; i < 6; i++)
			smp[i] <= CASES[k][3+i];
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (inReady !== 1'b1 && n < 50);
		inValid <= 1'b0;
		waitWords(1);
		w = i_dacmx_sink_model.got.pop_front();
		for (int j = 0; j < 4; j++)
			check(w[63-16*j -: 16], CASES[k][9+j]);
	endtask

	// ----------------------------------------------------------------
	// clock, timeout, sequence
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #50 clk = !clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			report_and_stop();
		end
	end

	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		resetPinN = 1'b1;
		powerdownPinN = 1'b1;
		pdBit = 1'b0;
		regAddr = 8'h00;
		regWrData = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
		inValid = 1'b0;
		stall = 1'b0;
		for (int i = 0; i < 6; i++)
			smp[i] = 16'h0000;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		regsChk(16'h0000, 16'h8080, 16'h8080);
		setRegs(16'hBFBF, 16'hBFBF, 16'hBFBF);
		regsChk(16'hBFBF, 16'hBFBF, 16'hBFBF);
		wr(8'h20, 16'h1234);
		rdChk(8'h20, 16'h0000);
		for (int s = 0; s < 3; s++)
		begin
			setRegs(16'h2A15, 16'h3F3F, 16'h0505);
			regsChk(16'h2A15, 16'h3F3F, 16'h0505);
			resetPinN <= (s != 0);
			powerdownPinN <= (s != 1);
			pdBit <= (s == 2);
			repeat (8) @(posedge clk);
			regsChk(16'h0000, 16'h8080, 16'h8080);
			setRegs(16'h0101, 16'h0202, 16'h0303);
			regsChk(16'h0000, 16'h8080, 16'h8080);
			resetPinN <= 1'b1;
			powerdownPinN <= 1'b1;
			pdBit <= 1'b0;
			repeat (8) @(posedge clk);
			regsChk(16'h0000, 16'h8080, 16'h8080);
		end
		// a write is not taken while the clock enable is low
		ce <= 1'b0;
		wr(`DACMX_ADDR_MIX1, 16'h0505);
		ce <= 1'b1;
		rdChk(`DACMX_ADDR_MIX1, 16'h8080);
		runCase(0);
		runCase(1);
		runCase(2);
		runCase(3);
		// fill with the sink stalled, then drain in order
		setRegs(16'h0000, 16'h8080, 16'h8080);
		stall <= 1'b1;
		inValid <= 1'b1;
		for (int i = 0; i < 6; i++)
			smp[i] <= 16'h0000;
		n = 0;
		repeat (30)
		begin
			@(posedge clk);
			if (inReady === 1'b1)
			begin
				n++;
				for (int i = 0; i < 6; i++)
					smp[i] <= 16'(n);
			end
		end
		inValid <= 1'b0;
		check(16'(n), 16'h0011);
		rdChk(`DACMX_ADDR_STATUS, 16'h0010);
		stall <= 1'b0;
		waitWords(17);
		for (int i = 0; i < 17; i++)
		begin
			check(i_dacmx_sink_model.got[i][63:48], 16'(i));
			check(i_dacmx_sink_model.got[i][15:0], 16'(i));
		end
		report_and_stop();
	end
endmodule // tb_dacmx_top
